//--- src/ats_pkg.sv
package ats_pkg;
  // register byte offsets
  localparam logic [7:0] ATS_CTRL = 8'h00;
  localparam logic [7:0] ATS_CMDR = 8'h04;
  localparam logic [7:0] ATS_STAT = 8'h08;
  localparam logic [7:0] ATS_WIN0 = 8'h10;
  // control fields
  localparam int ATS_C_MODE = 0;
  localparam int ATS_C_TWO = 2;
  localparam int ATS_C_ENC = 3;
  localparam int ATS_C_NTAR = 4;
  // window word a: enable, day type, start, end minute
  localparam int ATS_A_EN = 0;
  localparam int ATS_A_DT = 1;
  localparam int ATS_A_ST = 5;
  localparam int ATS_A_ET = 16;
  // window word b: start month/day, end month/day
  localparam int ATS_B_SM = 0;
  localparam int ATS_B_SD = 4;
  localparam int ATS_B_EM = 9;
  localparam int ATS_B_ED = 13;
  // day types; codes 3..9 are monday..sunday
  localparam logic [3:0] ATS_DT_EVERY = 4'h0;
  localparam logic [3:0] ATS_DT_WKDAY = 4'h1;
  localparam logic [3:0] ATS_DT_WKEND = 4'h2;
  localparam logic [3:0] ATS_DT_MON = 4'h3;
  localparam logic [3:0] ATS_DT_SUN = 4'h9;
  localparam logic [10:0] ATS_LAST_MIN = 11'h59f;
  localparam logic [3:0] ATS_LAST_MON = 4'hc;
  // reset values
  localparam logic [2:0] ATS_NTAR_RST = 3'h2;
  localparam logic [2:0] ATS_TAR_NONE = 3'h0;
  typedef enum logic [1:0] {
    ATS_M_CMD = 2'b00,
    ATS_M_INP = 2'b01,
    ATS_M_TOD = 2'b10
  } ats_mode_t;
endpackage

//--- src/ats_top.sv
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
// How it works
// (R1) three-state encoding: inputs 00 mean none
// (R2) first input high tariff one, second two
// (R3) command mode: tariff only from bus commands
// (R4) input mode follows selector levels continuously
// (R5) schedule mode matches day, time, date
// (R6) weekday comes in, never computed from date
// (R7) minute times inclusive through second 59
// (R8) day types; only everyday crosses midnight
// (R9) months one to twelve only
// (R10) end day one to thirty-one
// (R11) four independent schedule windows
// (R12) checker flags conflicting or overlapping windows
// (R13) input mode needs input one free
// (R14) tariff code binary, active input is one
// (R15) tariff count limited by free inputs
// (R16) setting: one or two selector inputs
// (R17) input two msb, input one lsb
// (R18) alternative encoding: code zero is tariff one
// (R19) reject window with start equal end
// (R20) same month needs start day before end
// (R21) no schedule match means no tariff
// (R22) date range may wrap across new year
module ats_top
  import ats_pkg::*;
#(
  parameter int NWIN = 4
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] sel_in_i,
  input wire logic free1_i,
  input wire logic free2_i,
  input wire logic [10:0] minute_i,
  input wire logic [2:0] weekday_i,
  input wire logic [3:0] month_i,
  input wire logic [4:0] day_i,
  output logic [2:0] tariff_o,
  output logic conflict_o,
  output logic refused_o
);

  typedef struct packed {
    ats_mode_t mode;
    logic two;
    logic enc;
    logic [2:0] ntar;
    logic [2:0] cmd;
    logic [NWIN-1:0][26:0] wa;
    logic [NWIN-1:0][17:0] wb;
    logic [2:0] tar;
    logic conf;
    logic refused;
    logic ack;
    logic [31:0] dat;
  } ats_st_t;

  ats_st_t st_q, st_d;
  logic [NWIN-1:0] en, bad, ok, hit, same_t;
  logic [NWIN-1:0][6:0] dmask;
  logic [NWIN-1:0][10:0] ts, te, ds, de;
  logic [10:0] cur_date;
  logic overlap;

  // circular range test; covers wrap past midnight or new year
  function automatic logic inr(input logic [10:0] x, s, e);
    inr = (s <= e) ? (x >= s && x <= e) : (x >= s || x <= e);
  endfunction

  // day type to weekday set, bit 0 monday
  function automatic logic [6:0] dmap(input logic [3:0] dt);
    if (dt == ATS_DT_EVERY)
      dmap = 7'h7f;
    else if (dt == ATS_DT_WKDAY)
      dmap = 7'h1f;
    else if (dt == ATS_DT_WKEND)
      dmap = 7'h60;
    else if (dt >= ATS_DT_MON && dt <= ATS_DT_SUN)
      dmap = 7'h01 << (dt - ATS_DT_MON); // [R8]
    else
      dmap = 7'h00;
  endfunction

  assign cur_date = {2'b00, month_i, day_i}; // [R6]

  // per-window decode, check and match
  for (genvar k = 0; k < NWIN; k++)
  begin : g_win // [R11]
    logic [3:0] dt, sm, em;
    logic [4:0] sd, ed;
    logic [7:0] dm8;
    assign dt = st_q.wa[k][ATS_A_DT +: 4];
    assign ts[k] = st_q.wa[k][ATS_A_ST +: 11];
    assign te[k] = st_q.wa[k][ATS_A_ET +: 11];
    assign sm = st_q.wb[k][ATS_B_SM +: 4];
    assign sd = st_q.wb[k][ATS_B_SD +: 5];
    assign em = st_q.wb[k][ATS_B_EM +: 4];
    assign ed = st_q.wb[k][ATS_B_ED +: 5];
    assign ds[k] = {2'b00, sm, sd};
    assign de[k] = {2'b00, em, ed};
    assign en[k] = st_q.wa[k][ATS_A_EN];
    assign dmask[k] = dmap(dt);
    assign bad[k] = (ts[k] == te[k]) // [R19]
      | (ts[k] > te[k] && dt != ATS_DT_EVERY) // [R8]
      | (sm == em && sd >= ed) // [R20]
      | (sm == 4'h0) | (sm > ATS_LAST_MON) // [R9]
      | (em == 4'h0) | (em > ATS_LAST_MON) // [R9]
      | (sd == 5'h00) | (ed == 5'h00) // [R10]
      | (dmask[k] == 7'h00)
      | (ts[k] > ATS_LAST_MIN) | (te[k] > ATS_LAST_MIN);
    assign ok[k] = en[k] & ~bad[k];
    assign same_t[k] = en[k] & (ts[k] == te[k]); // [R19]
    // weekday code 7 lands on the padding bit and matches nothing
    assign dm8 = {1'b0, dmask[k]};
    // inclusive minute compare holds all 60 s of the end minute
    assign hit[k] = ok[k] & dm8[weekday_i] // [R5]
      & inr(cur_date, ds[k], de[k]) // [R22]
      & inr(minute_i, ts[k], te[k]); // [R7]
  end

  // pairwise overlap: two circular ranges meet if a start lies in other
  always_comb
  begin
    overlap = 1'b0;
    for (int i = 0; i < NWIN; i++)
      for (int j = i + 1; j < NWIN; j++)
        if (ok[i] && ok[j] && (dmask[i] & dmask[j]) != 7'h00
            && (inr(ds[i], ds[j], de[j]) || inr(ds[j], ds[i], de[i]))
            && (inr(ts[i], ts[j], te[j]) || inr(ts[j], ts[i], te[i])))
          overlap = 1'b1; // [R12]
  end

  // next state: bus slave, configuration, tariff selection
  always_comb
  begin
    logic req, wr;
    logic [1:0] code;
    logic [2:0] t, nmax;
    logic [4:0] idx;
    logic [31:0] rd;
    logic win;
    st_d = st_q;
    req = wb_cyc_i & wb_stb_i & ~st_q.ack;
    wr = req & wb_we_i & (wb_sel_i == 4'hf);
    idx = wb_adr_i[7:3] - ATS_WIN0[7:3];
    // window words sit in eight-byte steps from the first window
    win = wb_adr_i[1:0] == 2'b00 && wb_adr_i >= ATS_WIN0
          && int'(idx) < NWIN;
    rd = 32'h0000_0000;
    t = ATS_TAR_NONE;
    code = 2'b00;
    nmax = 3'h0;
    st_d.ack = req;
    // register writes; partial-word writes are ignored
    if (wr && wb_adr_i == ATS_CTRL)
    begin
      if (wb_dat_i[ATS_C_MODE +: 2] == 2'b11
          || (wb_dat_i[ATS_C_MODE +: 2] == ATS_M_INP && !free1_i))
        st_d.refused = 1'b1; // [R13]
      else
      begin
        st_d.refused = 1'b0;
        st_d.mode = ats_mode_t'(wb_dat_i[ATS_C_MODE +: 2]);
      end
      st_d.two = wb_dat_i[ATS_C_TWO] & free2_i; // [R13] [R16]
      st_d.enc = wb_dat_i[ATS_C_ENC];
      nmax = st_d.two ? 3'h4 : 3'h2;
      st_d.ntar = (wb_dat_i[ATS_C_NTAR +: 3] > nmax) ? nmax
                : wb_dat_i[ATS_C_NTAR +: 3]; // [R15]
    end
    if (wr && wb_adr_i == ATS_CMDR && wb_dat_i[2:0] <= 3'h4)
      st_d.cmd = wb_dat_i[2:0]; // [R3]
    if (wr && win)
    begin
      if (wb_adr_i[2])
        st_d.wb[idx[1:0]] = wb_dat_i[17:0];
      else
        st_d.wa[idx[1:0]] = wb_dat_i[26:0];
    end
    // read mux; unmapped addresses read zero
    if (wb_adr_i == ATS_CTRL)
      rd = {25'h0, st_q.ntar, st_q.enc, st_q.two, st_q.mode};
    else if (wb_adr_i == ATS_CMDR)
      rd = {29'h0, st_q.cmd};
    else if (wb_adr_i == ATS_STAT)
      rd = {25'h0, free2_i, free1_i, st_q.refused, st_q.conf,
            st_q.tar};
    else if (win)
      rd = wb_adr_i[2] ? {14'h0, st_q.wb[idx[1:0]]}
                       : {5'h0, st_q.wa[idx[1:0]]};
    if (req && !wb_we_i)
      st_d.dat = rd;
    // tariff selection by mode
    unique case (st_q.mode)
      ATS_M_CMD:
        t = st_q.cmd; // [R3]
      ATS_M_INP:
      begin
        // input two only counts when set up and still free
        code = {st_q.two & free2_i & sel_in_i[1], sel_in_i[0]}; // [R17]
        t = st_q.enc ? {1'b0, code} + 3'h1 // [R18]
                     : {1'b0, code}; // [R1] [R2] [R14]
        if (t > st_q.ntar)
          t = ATS_TAR_NONE; // [R15]
        if (!free1_i)
          t = ATS_TAR_NONE;
      end // [R4]
      ATS_M_TOD:
      begin
        t = ATS_TAR_NONE; // [R21]
        for (int k = NWIN - 1; k >= 0; k--)
          if (hit[k])
            t = 3'(k + 1); // lowest window wins if checker ignored
      end
      default:
        t = ATS_TAR_NONE;
    endcase
    st_d.tar = t;
    st_d.conf = |(en & bad) | overlap; // [R12]
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
      st_q.mode <= ATS_M_CMD;
      st_q.ntar <= ATS_NTAR_RST;
    end
    else
      st_q <= st_d;
  end

  assign wb_dat_o = st_q.dat;
  assign wb_ack_o = st_q.ack;
  assign tariff_o = st_q.tar;
  assign conflict_o = st_q.conf;
  assign refused_o = st_q.refused;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_cmd_follows: assert property ( // [R3]
    st_q.mode == ATS_M_CMD |=> tariff_o == $past(st_q.cmd))
    else $error("command tariff not applied");
  a_inp_none: assert property ( // [R1]
    st_q.mode == ATS_M_INP && !st_q.enc && sel_in_i == 2'b00
    |=> tariff_o == ATS_TAR_NONE)
    else $error("code 00 gave a tariff");
  a_inp_two: assert property ( // [R2]
    st_q.mode == ATS_M_INP && !st_q.enc && st_q.two && free2_i
    && free1_i && st_q.ntar >= 3'h2 && sel_in_i == 2'b10
    |=> tariff_o == 3'h2)
    else $error("input two did not give tariff two");
  a_inp_msb: assert property ( // [R17]
    st_q.mode == ATS_M_INP && st_q.enc && st_q.two && free1_i
    && free2_i && st_q.ntar == 3'h4
    |=> tariff_o == {1'b0, $past(sel_in_i)} + 3'h1)
    else $error("binary code mapping wrong");
  a_tod_none: assert property ( // [R21]
    st_q.mode == ATS_M_TOD && hit == '0 |=> tariff_o == ATS_TAR_NONE)
    else $error("tariff without schedule match");
  a_refuse_inp: assert property ( // [R13]
    st_q.ack == 1'b0 && wb_cyc_i && wb_stb_i && wb_we_i
    && wb_sel_i == 4'hf && wb_adr_i == ATS_CTRL && !free1_i
    && wb_dat_i[1:0] == ATS_M_INP
    |=> refused_o && st_q.mode == $past(st_q.mode))
    else $error("input mode taken without free input");
  a_two_free: assert property ( // [R13]
    !free2_i && wb_cyc_i && wb_stb_i && wb_we_i && !st_q.ack
    && wb_sel_i == 4'hf && wb_adr_i == ATS_CTRL |=> !st_q.two)
    else $error("second input used while not free");
  a_equal_times: assert property ( // [R19]
    same_t != '0 |=> conflict_o)
    else $error("equal start and end not flagged");
  a_overlap_flag: assert property ( // [R12]
    overlap |=> conflict_o)
    else $error("overlapping windows not flagged");
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_tod_first: assert property ( // [R5]
    st_q.mode == ATS_M_TOD && hit[0] |=> tariff_o == 3'h1)
    else $error("first window match not applied");

  c_cmd_set: cover property (st_q.mode == ATS_M_CMD && tariff_o == 3'h3);
  c_inp_t2: cover property (st_q.mode == ATS_M_INP && tariff_o == 3'h2);
  c_tod_hit: cover property (st_q.mode == ATS_M_TOD && tariff_o == 3'h4);
  c_conflict: cover property (conflict_o && overlap);

endmodule // ats_top

//--- sim/ats_din_src.sv
`timescale 1ns/10ps
// far side: two digital contacts and their tariff assignment state
module ats_din_src (
  input wire logic clk_i,
  input wire logic [1:0] lvl_i,
  input wire logic asg1_i,
  input wire logic asg2_i,
  output logic [1:0] sel_o,
  output logic free1_o,
  output logic free2_o
);
  // contacts change only at edges, so the block never sees a glitch
  always_ff @(posedge clk_i)
  begin
    sel_o <= lvl_i;
    free1_o <= asg1_i;
    free2_o <= asg2_i;
  end
endmodule // ats_din_src

//--- sim/ats_top_test.sv
`timescale 1ns/10ps
module ats_top_test;
  import ats_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [1:0] lvl = 2'h0;
  logic asg1 = 1'b1;
  logic asg2 = 1'b1;
  logic [10:0] minute = 11'h0;
  logic [2:0] wday = 3'h0;
  logic [3:0] mon = 4'h1;
  logic [4:0] day = 5'h0a;
  logic [1:0] sel;
  logic free1, free2, ack, conflict, refused;
  logic [31:0] dat_o;
  logic [2:0] tariff;
  logic [31:0] rng = 32'hcfca;
  int err_count = 0;
  int comparisons = 0;

  always #25 clk_i = ~clk_i;

  ats_top ats_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .sel_in_i(sel),
    .free1_i(free1), .free2_i(free2), .minute_i(minute), .weekday_i(wday),
    .month_i(mon), .day_i(day), .tariff_o(tariff), .conflict_o(conflict),
    .refused_o(refused));
  ats_din_src ats_din_src_i (.clk_i(clk_i), .lvl_i(lvl), .asg1_i(asg1),
    .asg2_i(asg2), .sel_o(sel), .free1_o(free1), .free2_o(free2));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] wa(input logic [3:0] dt,
    input logic [10:0] st, input logic [10:0] et);
    return {5'h0, et, st, dt, 1'b1};
  endfunction

  function automatic logic [31:0] wbw(input logic [3:0] sm,
    input logic [4:0] sd, input logic [3:0] em, input logic [4:0] ed);
    return {14'h0, ed, em, sd, sm};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic cycle: hold everything until ack is sampled high
  // no local limit; a hung slave is left to the watchdog
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // contact edge, partner edge, then the tariff register
  task automatic wt();
    repeat (3) @(posedge clk_i);
  endtask

  task automatic win2(input logic [31:0] a, input logic [31:0] b,
    input logic e);
    bus(1'b1, ATS_WIN0 + 8'h10, a);
    bus(1'b1, ATS_WIN0 + 8'h14, b);
    wt();
    chk(conflict, e);
  endtask

  task automatic sc(input logic [10:0] m, input logic [2:0] d,
    input logic [3:0] mo, input logic [2:0] e);
    minute <= m;
    wday <= d;
    mon <= mo;
    wt();
    chk(tariff, e);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // generous bound: the sequence needs well under a thousand cycles
  initial
  begin
    #200000;
    err_count++;
    finish_test();
  end

  initial
  begin
    logic [1:0] c;
    logic [2:0] e;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, ATS_STAT, 32'h0);
    chk(rdat, 32'h60);
    bus(1'b0, 8'h80, 32'h0);
    chk(rdat, 32'h0);
    $display("test reset and map done");
    bus(1'b1, ATS_CMDR, 32'h3);
    wt();
    chk(tariff, 3'h3);
    bus(1'b1, ATS_CMDR, 32'h5);
    wt();
    chk(tariff, 3'h3);
    asg1 <= 1'b0;
    wt();
    bus(1'b1, ATS_CTRL, 32'h45);
    chk(refused, 1'b1);
    wt();
    chk(tariff, 3'h3);
    asg1 <= 1'b1;
    $display("test command mode done");
    // both encodings, with and without the second contact
    for (int p = 0; p < 4; p++)
    begin
      asg2 <= p[1];
      wt();
      bus(1'b1, ATS_CTRL, {25'h0, 3'h4, p[0], 1'b1, 2'h1});
      chk(refused, 1'b0);
      for (int k = 0; k < 6; k++)
      begin
        rng = xs(rng);
        lvl <= rng[1:0];
        wt();
        c = {p[1] & rng[1], rng[0]};
        e = p[0] ? {1'b0, c} + 3'h1 : {1'b0, c};
        if (e > (p[1] ? 3'h4 : 3'h2))
          e = 3'h0;
        chk(tariff, e);
      end
    end
    asg1 <= 1'b0;
    wt();
    chk(tariff, 3'h0);
    asg1 <= 1'b1;
    $display("test input mode done");
    bus(1'b1, ATS_WIN0, wa(ATS_DT_EVERY, 11'h564, 11'h01e));
    bus(1'b1, ATS_WIN0 + 8'h4, wbw(4'h1, 5'h01, 4'hc, 5'h1f));
    bus(1'b1, ATS_WIN0 + 8'h8, wa(ATS_DT_WKDAY, 11'h03c, 11'h04b));
    bus(1'b1, ATS_WIN0 + 8'hc, wbw(4'hc, 5'h01, 4'h2, 5'h1c));
    bus(1'b1, ATS_CTRL, 32'h2);
    sc(11'h04b, 3'h0, 4'h1, 3'h2);
    sc(11'h04c, 3'h0, 4'h1, 3'h0);
    sc(11'h00a, 3'h5, 4'h6, 3'h1);
    sc(11'h046, 3'h5, 4'h1, 3'h0);
    sc(11'h046, 3'h2, 4'h6, 3'h0);
    sc(11'h046, 3'h2, 4'hc, 3'h2);
    chk(conflict, 1'b0);
    win2(wa(ATS_DT_EVERY, 11'h078, 11'h078), wbw(4'h1, 5'h01, 4'hc, 5'h1f),
      1'b1);
    win2(wa(ATS_DT_MON, 11'h078, 11'h082), wbw(4'h3, 5'h09, 4'h3, 5'h09),
      1'b1);
    win2(wa(ATS_DT_MON, 11'h078, 11'h082), wbw(4'hd, 5'h01, 4'hd, 5'h05),
      1'b1);
    win2(wa(ATS_DT_MON, 11'h078, 11'h082), wbw(4'h3, 5'h01, 4'h4, 5'h00),
      1'b1);
    win2(wa(ATS_DT_MON, 11'h082, 11'h078), wbw(4'h3, 5'h01, 4'h4, 5'h05),
      1'b1);
    win2(wa(ATS_DT_EVERY, 11'h000, 11'h014), wbw(4'h1, 5'h01, 4'hc, 5'h1f),
      1'b1);
    win2(wa(ATS_DT_MON, 11'h078, 11'h082), wbw(4'h3, 5'h01, 4'h4, 5'h05),
      1'b0);
    // fourth window: write, read back, then make it win
    bus(1'b1, ATS_WIN0 + 8'h18, wa(ATS_DT_SUN, 11'h168, 11'h1e0));
    bus(1'b1, ATS_WIN0 + 8'h1c, wbw(4'h1, 5'h01, 4'hc, 5'h1f));
    bus(1'b0, ATS_WIN0 + 8'h18, 32'h0);
    chk(rdat, wa(ATS_DT_SUN, 11'h168, 11'h1e0));
    sc(11'h190, 3'h6, 4'h6, 3'h4);
    chk(conflict, 1'b0);
    // last day of a wrapping range, then the day after it
    day <= 5'h1c;
    sc(11'h046, 3'h0, 4'h2, 3'h2);
    day <= 5'h1d;
    sc(11'h046, 3'h0, 4'h2, 3'h0);
    $display("test schedule mode done");
    finish_test();
  end
endmodule // ats_top_test
